// ===== hdl/atp_ambient_tracker.sv
/*
 * atp_ambient_tracker: per-stage ambient tracking, proximity detection,
 * offset drift compensation, threshold recompute and interrupt output.
 * Assumes converter samples arrive on clk_sys as one-cycle valid pulses and
 * a host on the same clock drives the plain register port.
 */
`timescale 1ns/1ps
module atp_ambient_tracker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [11:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    input wire logic sampleValid,
    input wire logic [3:0] sampleStage,
    input wire logic [15:0] sampleData,
    output logic intOut
);
    localparam int NS = atp_pkg::NUM_STAGES;

    logic rstMeta_ff;
    logic rstSync_ff;

    // configuration
    logic [15:0] skip_ff, nxt_skip;
    logic [3:0] fastSkip_ff, nxt_fastSkip;
    logic [15:0] ctrl1_ff, nxt_ctrl1;
    logic [9:0] sens_ff, nxt_sens;

    // stage memory
    logic [15:0] fast_ff [NS][atp_pkg::FAST_DEPTH], nxt_fast [NS][atp_pkg::FAST_DEPTH];
    logic [15:0] slow_ff [NS][atp_pkg::SLOW_DEPTH], nxt_slow [NS][atp_pkg::SLOW_DEPTH];
    logic [15:0] upOff_ff [NS], nxt_upOff [NS];
    logic [15:0] loOff_ff [NS], nxt_loOff [NS];
    logic [15:0] upLim_ff [NS], nxt_upLim [NS];
    logic [15:0] loLim_ff [NS], nxt_loLim [NS];
    logic [15:0] amb_ff [NS], nxt_amb [NS];
    logic [3:0] fastCnt_ff [NS], nxt_fastCnt [NS];
    logic [3:0] slowCnt_ff [NS], nxt_slowCnt [NS];
    logic [NS-1:0] prox_ff, nxt_prox;
    logic [NS-1:0] touch_ff, nxt_touch;
    logic intOut_ff, nxt_intOut;
    logic [15:0] rdData_ff, nxt_rdData;

    // sample-path signals
    logic [3:0] stg, slowLimit;
    logic stgOk, enable, lowPower, prox1, prox2, updExceed, proxNow, slowEn;
    logic fastTake, slowTick, slowWrite, touchNow;
    logic [15:0] fastNewest, fastFourth, fastAvg, rateLim, hoverLim, updLim, newAmb;
    logic [17:0] fastSum, slowSum, upSum, loSum;
    logic signed [17:0] drift;

    // host address decode
    logic [3:0] aBank;
    logic [3:0] aStage;
    logic [3:0] aWord;
    logic aStageOk;

    function automatic logic [15:0] lim_calc(input logic [15:0] amb, input logic [15:0] off,
                                            input logic [3:0] code);
        logic signed [17:0] span;
        logic [6:0] pct;
        logic signed [25:0] prod;
        logic signed [17:0] res;
        logic signed [17:0] sum;
        span = $signed({2'b00, off}) - $signed({2'b00, amb});
        pct = 7'(code) * 7'(atp_pkg::PCT_STEP) + 7'(atp_pkg::PCT_BASE);
        prod = span * $signed({1'b0, pct});
        res = prod[(18 + atp_pkg::PCT_SHIFT - 1):atp_pkg::PCT_SHIFT];
        sum = $signed({2'b00, amb}) + res;
        return sum[15:0];
    endfunction : lim_calc

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    assign aBank = regAddr[11:8];
    assign aStage = regAddr[7:4];
    assign aWord = regAddr[3:0];
    assign aStageOk = aStage <= atp_pkg::LAST_STAGE;

    assign enable = sens_ff[atp_pkg::ENABLE_BIT];
    assign lowPower = sens_ff[atp_pkg::LOW_POWER_BIT];
    assign stgOk = sampleStage <= atp_pkg::LAST_STAGE;
    // out-of-range stage never indexes past the arrays
    assign stg = stgOk ? sampleStage : 4'h0;

    assign fastNewest = fast_ff[stg][0];
    assign fastFourth = fast_ff[stg][3];
    assign fastSum = 18'(fast_ff[stg][0]) + 18'(fast_ff[stg][1])
                   + 18'(fast_ff[stg][2]) + 18'(fast_ff[stg][3]);
    assign fastAvg = fastSum[17:2];
    assign rateLim = {6'h00, ctrl1_ff[atp_pkg::RATE_LSB +: 6], 4'h0};
    assign hoverLim = {4'h0, ctrl1_ff[atp_pkg::HOVER_LSB +: 8], 4'h0};
    assign updLim = {14'h0000, ctrl1_ff[atp_pkg::UPD_LSB +: 2]};

    atp_abs_exceed uRate (
        .valA(fastNewest),
        .valB(fastFourth),
        .limit(rateLim),
        .exceeds(prox1)
    );

    atp_abs_exceed uHover (
        .valA(fastAvg),
        .valB(amb_ff[stg]),
        .limit(hoverLim),
        .exceeds(prox2)
    );

    atp_abs_exceed uUpdate (
        .valA(slow_ff[stg][0]),
        .valB(sampleData),
        .limit(updLim),
        .exceeds(updExceed)
    );

    assign proxNow = prox1 | prox2;
    assign slowEn = updExceed & ~proxNow;

    always_comb begin
        fastTake = fastCnt_ff[stg] >= fastSkip_ff;
        // full power: code 0 keeps one sample in four; low power: code 0 keeps all
        slowLimit = lowPower ? {2'b00, skip_ff[atp_pkg::LP_SKIP_LSB +: 2]}
                             : 4'((({2'b00, skip_ff[atp_pkg::FP_SKIP_LSB +: 2]}) + 4'h1)
                                  * atp_pkg::FP_SKIP_MULT - 4'h1);
        slowTick = fastTake && (slowCnt_ff[stg] >= slowLimit);
        slowWrite = slowTick && slowEn && !proxNow && !touch_ff[stg];
        slowSum = 18'(sampleData) + 18'(slow_ff[stg][0]) + 18'(slow_ff[stg][1])
                + 18'(slow_ff[stg][2]);
        newAmb = slowSum[17:2];
        drift = $signed({2'b00, newAmb}) - $signed({2'b00, amb_ff[stg]});
        upSum = 18'($signed({2'b00, upOff_ff[stg]}) + drift);
        loSum = 18'($signed({2'b00, loOff_ff[stg]}) + drift);
        touchNow = (sampleData > upLim_ff[stg]) || (sampleData < loLim_ff[stg]);
    end

    // configuration registers
    always_comb begin
        nxt_skip = skip_ff;
        nxt_fastSkip = fastSkip_ff;
        nxt_ctrl1 = ctrl1_ff;
        nxt_sens = sens_ff;
        if (regWr) begin
            unique case (regAddr)
                atp_pkg::ADDR_SKIP: nxt_skip = regWrData;
                atp_pkg::ADDR_FAST_SKIP: nxt_fastSkip = regWrData[atp_pkg::FF_SKIP_LSB +: 4];
                atp_pkg::ADDR_CTRL1: nxt_ctrl1 = regWrData;
                atp_pkg::ADDR_SENS: nxt_sens = regWrData[9:0];
                default: ;
            endcase
        end
    end

    // stage memory: sample path first, host write after it
    always_comb begin
        nxt_fast = fast_ff;
        nxt_slow = slow_ff;
        nxt_upOff = upOff_ff;
        nxt_loOff = loOff_ff;
        nxt_upLim = upLim_ff;
        nxt_loLim = loLim_ff;
        nxt_amb = amb_ff;
        nxt_fastCnt = fastCnt_ff;
        nxt_slowCnt = slowCnt_ff;
        nxt_prox = prox_ff;
        nxt_touch = touch_ff;
        if (sampleValid && stgOk && enable) begin
            nxt_prox[stg] = proxNow;
            nxt_touch[stg] = touchNow;
            if (fastTake) begin
                nxt_fastCnt[stg] = 4'h0;
                for (int i = atp_pkg::FAST_DEPTH - 1; i > 0; i--) begin
                    nxt_fast[stg][i] = fast_ff[stg][i-1];
                end
                nxt_fast[stg][0] = sampleData;
                nxt_slowCnt[stg] = slowTick ? 4'h0 : slowCnt_ff[stg] + 4'h1;
            end else begin
                nxt_fastCnt[stg] = fastCnt_ff[stg] + 4'h1;
            end
            if (slowWrite) begin
                for (int i = atp_pkg::SLOW_DEPTH - 1; i > 0; i--) begin
                    nxt_slow[stg][i] = slow_ff[stg][i-1];
                end
                nxt_slow[stg][0] = sampleData;
                nxt_amb[stg] = newAmb;
                nxt_upOff[stg] = upSum[15:0];
                nxt_loOff[stg] = loSum[15:0];
            end
            // limits recompute on each accepted sample from the updated ambient and offsets
            nxt_upLim[stg] = lim_calc(nxt_amb[stg], nxt_upOff[stg],
                                      sens_ff[atp_pkg::POS_SENS_LSB +: 4]);
            nxt_loLim[stg] = lim_calc(nxt_amb[stg], nxt_loOff[stg],
                                      sens_ff[atp_pkg::NEG_SENS_LSB +: 4]);
        end
        if (regWr && aStageOk) begin
            if (aBank == atp_pkg::BANK_STAGE) begin
                if (aWord == atp_pkg::W_UP_OFF) begin
                    nxt_upOff[aStage] = regWrData;
                end else if (aWord == atp_pkg::W_LO_OFF) begin
                    nxt_loOff[aStage] = regWrData;
                end
            end else if (aBank == atp_pkg::BANK_FIFO) begin
                if (aWord < atp_pkg::W_SLOW0) begin
                    nxt_fast[aStage][aWord[1:0]] = regWrData;
                end else if (aWord < 4'h8) begin
                    nxt_slow[aStage][aWord[1:0]] = regWrData;
                end
            end
        end
        nxt_intOut = |nxt_touch;
    end

    // read port: data in the cycle after the strobe, zero when unmapped
    always_comb begin
        nxt_rdData = 16'h0000;
        if (regRd) begin
            if (aBank == atp_pkg::BANK_GLOBAL) begin
                unique case (regAddr)
                    atp_pkg::ADDR_SKIP: nxt_rdData = skip_ff;
                    atp_pkg::ADDR_FAST_SKIP: nxt_rdData = {12'h000, fastSkip_ff};
                    atp_pkg::ADDR_CTRL1: nxt_rdData = ctrl1_ff;
                    atp_pkg::ADDR_SENS: nxt_rdData = {6'h00, sens_ff};
                    atp_pkg::ADDR_PROX: nxt_rdData = {4'h0, prox_ff};
                    atp_pkg::ADDR_TOUCH: nxt_rdData = {4'h0, touch_ff};
                    default: nxt_rdData = 16'h0000;
                endcase
            end else if (aBank == atp_pkg::BANK_STAGE && aStageOk) begin
                unique case (aWord)
                    atp_pkg::W_UP_OFF: nxt_rdData = upOff_ff[aStage];
                    atp_pkg::W_LO_OFF: nxt_rdData = loOff_ff[aStage];
                    atp_pkg::W_UP_LIM: nxt_rdData = upLim_ff[aStage];
                    atp_pkg::W_LO_LIM: nxt_rdData = loLim_ff[aStage];
                    atp_pkg::W_AMB: nxt_rdData = amb_ff[aStage];
                    default: nxt_rdData = 16'h0000;
                endcase
            end else if (aBank == atp_pkg::BANK_FIFO && aStageOk) begin
                if (aWord < atp_pkg::W_SLOW0) begin
                    nxt_rdData = fast_ff[aStage][aWord[1:0]];
                end else if (aWord < 4'h8) begin
                    nxt_rdData = slow_ff[aStage][aWord[1:0]];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstSync_ff) begin
        if (!rstSync_ff) begin
            skip_ff <= atp_pkg::SKIP_RST;
            fastSkip_ff <= atp_pkg::FAST_SKIP_RST;
            ctrl1_ff <= atp_pkg::CTRL1_RST;
            sens_ff <= atp_pkg::SENS_RST;
            rdData_ff <= 16'h0000;
            intOut_ff <= 1'b0;
            prox_ff <= '0;
            touch_ff <= '0;
            for (int s = 0; s < NS; s++) begin
                for (int i = 0; i < atp_pkg::FAST_DEPTH; i++) begin
                    fast_ff[s][i] <= 16'h0000;
                    slow_ff[s][i] <= 16'h0000;
                end
                upOff_ff[s] <= 16'h0000;
                loOff_ff[s] <= 16'h0000;
                upLim_ff[s] <= 16'hffff;
                loLim_ff[s] <= 16'h0000;
                amb_ff[s] <= 16'h0000;
                fastCnt_ff[s] <= 4'h0;
                slowCnt_ff[s] <= 4'h0;
            end
        end else if (clkEn) begin
            skip_ff <= nxt_skip;
            fastSkip_ff <= nxt_fastSkip;
            ctrl1_ff <= nxt_ctrl1;
            sens_ff <= nxt_sens;
            rdData_ff <= nxt_rdData;
            intOut_ff <= nxt_intOut;
            prox_ff <= nxt_prox;
            touch_ff <= nxt_touch;
            fast_ff <= nxt_fast;
            slow_ff <= nxt_slow;
            upOff_ff <= nxt_upOff;
            loOff_ff <= nxt_loOff;
            upLim_ff <= nxt_upLim;
            loLim_ff <= nxt_loLim;
            amb_ff <= nxt_amb;
            fastCnt_ff <= nxt_fastCnt;
            slowCnt_ff <= nxt_slowCnt;
        end
    end

    assign regRdData = rdData_ff;
    assign intOut = intOut_ff;
endmodule : atp_ambient_tracker

// ===== hdl/atp_pkg.sv
/*
 * atp_pkg: shared constants of the ambient tracking proximity calibration block.
 * Assumes a 12-bit register address, 16-bit data and per-stage memory banks.
 */
package atp_pkg;
    localparam int NUM_STAGES = 12;
    localparam int FAST_DEPTH = 4;
    localparam int SLOW_DEPTH = 4;
    localparam logic [3:0] LAST_STAGE = 4'hb;

    // global registers
    localparam logic [11:0] ADDR_SKIP = 12'h001;
    localparam logic [11:0] ADDR_FAST_SKIP = 12'h002;
    localparam logic [11:0] ADDR_CTRL1 = 12'h003;
    localparam logic [11:0] ADDR_SENS = 12'h005;
    localparam logic [11:0] ADDR_PROX = 12'h006;
    localparam logic [11:0] ADDR_TOUCH = 12'h007;

    // per-stage banks: addr[11:8] bank, addr[7:4] stage, addr[3:0] word
    localparam logic [3:0] BANK_GLOBAL = 4'h0;
    localparam logic [3:0] BANK_STAGE = 4'h2;
    localparam logic [3:0] BANK_FIFO = 4'h3;
    localparam logic [3:0] W_UP_OFF = 4'h0;
    localparam logic [3:0] W_LO_OFF = 4'h1;
    localparam logic [3:0] W_UP_LIM = 4'h2;
    localparam logic [3:0] W_LO_LIM = 4'h3;
    localparam logic [3:0] W_AMB = 4'h4;
    localparam logic [3:0] W_FAST0 = 4'h0;
    localparam logic [3:0] W_SLOW0 = 4'h4;

    // field positions
    localparam int FF_SKIP_LSB = 0;
    localparam int FP_SKIP_LSB = 12;
    localparam int LP_SKIP_LSB = 14;
    localparam int HOVER_LSB = 0;
    localparam int RATE_LSB = 8;
    localparam int UPD_LSB = 14;
    localparam int POS_SENS_LSB = 0;
    localparam int NEG_SENS_LSB = 4;
    localparam int LOW_POWER_BIT = 8;
    localparam int ENABLE_BIT = 9;

    // reset values
    localparam logic [15:0] SKIP_RST = 16'h0000;
    localparam logic [3:0] FAST_SKIP_RST = 4'h0;
    localparam logic [15:0] CTRL1_RST = 16'h0000;
    localparam logic [9:0] SENS_RST = 10'h000;

    // level scaling and threshold percentage: (code * 3 + 16) / 64
    localparam int LEVEL_SHIFT = 4;
    localparam int PCT_BASE = 16;
    localparam int PCT_STEP = 3;
    localparam int PCT_SHIFT = 6;
    localparam logic [3:0] FP_SKIP_MULT = 4'h4;
endpackage : atp_pkg

// ===== hdl/atp_abs_exceed.sv
/*
 * atp_abs_exceed: magnitude comparator, |a - b| > limit.
 * Pure combinational; inputs are unsigned 16-bit converter codes.
 */
`timescale 1ns/1ps
module atp_abs_exceed (
    input wire logic [15:0] valA,
    input wire logic [15:0] valB,
    input wire logic [15:0] limit,
    output logic exceeds
);
    logic signed [16:0] diff;
    logic [16:0] mag;

    always_comb begin
        diff = $signed({1'b0, valA}) - $signed({1'b0, valB});
        // absolute value, so approach and retreat both count
        mag = diff[16] ? 17'(-diff) : 17'(diff);
        exceeds = mag > {1'b0, limit};
    end
endmodule : atp_abs_exceed

// ===== testbench/atp_host_bfm.sv
/*
 * atp_host_bfm: host model driving the plain register port of the tracker.
 * Assumes clk_sys from the bench and one caller at a time.
 */
`timescale 1ns/1ps
module atp_host_bfm (
    input wire logic clk_sys,
    output logic [11:0] regAddr,
    output logic [15:0] regWrData,
    output logic regWr,
    output logic regRd,
    input wire logic [15:0] regRdData
);
    initial begin
        regAddr = 12'h000;
        regWrData = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
    end

    // released lines show the inverse so stale values never pass for data
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [15:0] q);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        regAddr <= ~a;
        #1 q = regRdData;
    endtask : rd

    // write then read back with no gap between the strobes
    task automatic wrrd(input logic [11:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
        regRd <= 1'b1;
        regWrData <= ~d;
        @(posedge clk_sys);
        regRd <= 1'b0;
        regAddr <= ~a;
        #1 q = regRdData;
    endtask : wrrd
endmodule : atp_host_bfm

// ===== testbench/atp_tracker_chk.sv
/*
 * atp_tracker_chk: port-level assertions on the ambient tracker.
 * Assumes binding to atp_ambient_tracker; clkEn may drop between transfers.
 */
`timescale 1ns/1ps
module atp_tracker_chk (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [11:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdData,
    input wire logic sampleValid,
    input wire logic [3:0] sampleStage,
    input wire logic [15:0] sampleData,
    input wire logic intOut
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_rd_idle_zero: assert property (
        !$past(regRd) |-> regRdData == 16'h0000)
        else $error("read data present without a read");
    a_skip_readback: assert property (
        regWr && regAddr == atp_pkg::ADDR_SKIP ##1 regRd && regAddr == atp_pkg::ADDR_SKIP
        |=> regRdData == $past(regWrData, 2))
        else $error("skip control readback wrong");
    a_ctrl_readback: assert property (
        regWr && regAddr == atp_pkg::ADDR_CTRL1 ##1 regRd && regAddr == atp_pkg::ADDR_CTRL1
        |=> regRdData == $past(regWrData, 2))
        else $error("ambient control readback wrong");
    a_off_readback: assert property (
        regWr && regAddr[11:8] == atp_pkg::BANK_STAGE && regAddr[3:0] == atp_pkg::W_UP_OFF
        && regAddr[7:4] <= atp_pkg::LAST_STAGE ##1 regRd && $stable(regAddr)
        |=> regRdData == $past(regWrData, 2))
        else $error("stage offset readback wrong");
    a_fifo_readback: assert property (
        regWr && regAddr[11:8] == atp_pkg::BANK_FIFO && !regAddr[3]
        && regAddr[7:4] <= atp_pkg::LAST_STAGE ##1 regRd && $stable(regAddr)
        |=> regRdData == $past(regWrData, 2))
        else $error("fifo word readback wrong");
    a_unmapped_zero: assert property (
        regRd && regAddr == 12'h0f0 |=> regRdData == 16'h0000)
        else $error("unmapped read not zero");
    a_int_on_sample: assert property (
        $changed(intOut) |-> $past(sampleValid) && $past(sampleStage) <= atp_pkg::LAST_STAGE)
        else $error("interrupt moved without an accepted sample");
    a_ignored_stage: assert property (
        $past(sampleValid) && $past(sampleStage) > atp_pkg::LAST_STAGE |-> $stable(intOut))
        else $error("out of range stage changed interrupt");
endmodule : atp_tracker_chk

// ===== testbench/tb.sv
/*
 * tb: self-checking bench for atp_ambient_tracker.
 * Assumes the host model drives the register port and the bench drives samples.
 */
`timescale 1ns/1ps
module tb;
    logic clk_sys, rst_n, clkEn, regWr, regRd, sampleValid, intOut;
    logic [11:0] regAddr;
    logic [15:0] regWrData, regRdData, sampleData, q, d;
    logic [3:0] sampleStage, s;
    logic [31:0] seed;
    int mismatches, cmp_count, v, w0, w3, up, lo, cp, cn, eu, el;
    logic [11:0] tAddr [14] = '{12'h001, 12'h002, 12'h003, 12'h005, 12'h006, 12'h007,
        12'h250, 12'h251, 12'h252, 12'h253, 12'h254, 12'h352, 12'h357, 12'h0f0};
    logic [15:0] tMask [14] = '{16'hffff, 16'h000f, 16'hffff, 16'h03ff, 16'h0, 16'h0,
        16'hffff, 16'hffff, 16'h0, 16'h0, 16'h0, 16'hffff, 16'hffff, 16'h0};
    logic [15:0] tRst [14] = '{0, 0, 0, 0, 0, 0, 0, 0, 16'hffff, 0, 0, 0, 0, 0};
    logic [15:0] tSens [7] = '{16'h0200, 16'h0200, 16'h0200, 16'h0300, 16'h0300, 16'h0300,
        16'h0300};
    logic [15:0] tSkip [7] = '{16'h0000, 16'h1000, 16'h0000, 16'h0000, 16'h8000, 16'h4000, 0};
    logic [15:0] tFs [7] = '{0, 0, 1, 0, 0, 0, 0};
    logic [15:0] tCtl [7] = '{16'h3fff, 16'h3fff, 16'h3fff, 16'h3fff, 16'h3fff, 16'h00ff,
        16'hffff};
    int tN [7] = '{4, 8, 8, 1, 3, 2, 1};
    logic [15:0] tV [7] = '{16'h0124, 16'h0248, 16'h0100, 16'h0064, 16'h0200, 16'h0050, 3};
    logic [15:0] tE [7] = '{16'h0124, 16'h0248, 16'h0100, 16'h0064, 16'h0200, 0, 0};

    atp_ambient_tracker i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .sampleValid(sampleValid), .sampleStage(sampleStage),
        .sampleData(sampleData), .intOut(intOut));
    atp_host_bfm i_host (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic smp(input logic [3:0] st, input logic [15:0] dt);
        @(posedge clk_sys);
        sampleValid <= 1'b1;
        sampleStage <= st;
        sampleData <= dt;
        @(posedge clk_sys);
        sampleValid <= 1'b0;
        sampleData <= ~dt;
        #1;
    endtask : smp

    // full reset per scenario so skip counters start from zero
    task automatic rst();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask : rst

    task automatic results();
        if (mismatches == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    initial begin
        #(40 * 20000);
        mismatches++;
        results();
    end

    initial begin
        seed = 32'hf13040fd;
        rst_n = 1'b0;
        clkEn = 1'b1;
        sampleValid = 1'b0;
        sampleStage = 4'h0;
        sampleData = 16'h0000;
        mismatches = 0;
        cmp_count = 0;
        rst();
        for (int i = 0; i < 14; i++) begin
            i_host.rd(tAddr[i], q);
            chk(q, tRst[i]);
            d = 16'(rnd());
            i_host.wrrd(tAddr[i], d, q);
            chk(q, tRst[i] | (d & tMask[i]));
        end
        rst();
        i_host.wr(atp_pkg::ADDR_SENS, 16'h0200);
        for (int m = 0; m < 2; m++) for (int e = 0; e < 2; e++) begin
            s = 4'(rnd() % 12);
            v = int'(rnd() % 62) + 1;
            w0 = (m == 0) ? 2000 : v * 16 + e;
            w3 = (m == 0) ? w0 - v * 16 - e : w0;
            i_host.wr(atp_pkg::ADDR_CTRL1, (m == 0) ? 16'(v << 8 | 255) : 16'(16'h3f00 | v));
            for (int k = 0; k < 4; k++) begin
                i_host.wr({atp_pkg::BANK_FIFO, s, 4'(k)}, 16'((k == 3) ? w3 : w0));
            end
            smp(s, 16'(w0));
            i_host.rd(atp_pkg::ADDR_PROX, q);
            chk({15'h0, q[s]}, 16'(e));
        end
        for (int i = 0; i < 2; i++) begin
            rst();
            s = 4'(rnd() % 12);
            cp = int'(rnd() % 16);
            cn = int'(rnd() % 16);
            up = int'(rnd() % 32'h3000) + 32'h1000;
            lo = int'(rnd() % 32'h0300) + 32'h0100;
            i_host.wr(atp_pkg::ADDR_SENS, 16'(32'h0200 | cn << 4 | cp));
            i_host.wr({atp_pkg::BANK_STAGE, s, atp_pkg::W_UP_OFF}, 16'(up));
            i_host.wr({atp_pkg::BANK_STAGE, s, atp_pkg::W_LO_OFF}, 16'(lo));
            smp(s, 16'h0001);
            chk({15'h0, intOut}, 16'h0000);
            eu = up * (cp * 3 + 16) >> 6;
            el = lo * (cn * 3 + 16) >> 6;
            i_host.rd({atp_pkg::BANK_STAGE, s, atp_pkg::W_UP_LIM}, q);
            chk(q, 16'(eu));
            i_host.rd({atp_pkg::BANK_STAGE, s, atp_pkg::W_LO_LIM}, q);
            chk(q, 16'(el));
            smp(s, 16'(eu + 1));
            chk({15'h0, intOut}, 16'h0001);
            smp(4'hc + 4'(rnd() % 4), 16'(el + 1));
            chk({15'h0, intOut}, 16'h0001);
            smp(s, 16'(el + 1));
            chk({15'h0, intOut}, 16'h0000);
            // clock enable low: a crossing sample must leave intOut frozen
            @(posedge clk_sys);
            clkEn <= 1'b0;
            smp(s, 16'(el - 1));
            chk({15'h0, intOut}, 16'h0000);
            @(posedge clk_sys);
            clkEn <= 1'b1;
            smp(s, 16'(el - 1));
            chk({15'h0, intOut}, 16'h0001);
        end
        for (int i = 0; i < 7; i++) begin
            rst();
            s = 4'(rnd() % 12);
            i_host.wr(atp_pkg::ADDR_SENS, tSens[i]);
            i_host.wr(atp_pkg::ADDR_SKIP, tSkip[i]);
            i_host.wr(atp_pkg::ADDR_FAST_SKIP, tFs[i]);
            i_host.wr(atp_pkg::ADDR_CTRL1, tCtl[i]);
            i_host.wr({atp_pkg::BANK_STAGE, s, atp_pkg::W_UP_OFF}, 16'h4000);
            for (int k = 1; k < tN[i]; k++) smp(s, tV[i]);
            i_host.rd({atp_pkg::BANK_FIFO, s, atp_pkg::W_SLOW0}, q);
            chk(q, 16'h0000);
            smp(s, tV[i]);
            i_host.rd({atp_pkg::BANK_FIFO, s, atp_pkg::W_SLOW0}, q);
            chk(q, tE[i]);
            i_host.rd({atp_pkg::BANK_STAGE, s, atp_pkg::W_AMB}, q);
            chk(q, tE[i] >> 2);
            i_host.rd({atp_pkg::BANK_STAGE, s, atp_pkg::W_UP_OFF}, q);
            chk(q, 16'h4000 + (tE[i] >> 2));
        end
        results();
    end
endmodule : tb

bind atp_ambient_tracker atp_tracker_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .sampleValid(sampleValid), .sampleStage(sampleStage),
    .sampleData(sampleData), .intOut(intOut));
